// ==== verilog/rx_status_pkg.sv ====
/*
  Constants for the receiver control and status register: bit positions,
  mode encodings, reset values and the number of watched modem lines.
  Assumes nothing of its surroundings beyond a 16-bit register word.
*/
package rx_status_pkg;

  localparam int unsigned REG_WIDTH = 16;

  // Bit positions in receiver_control_status
  localparam int unsigned BIT_MODEM_CHANGE   = 15;
  localparam int unsigned BIT_RING           = 14;
  localparam int unsigned BIT_SEND_PERMIT    = 13;
  localparam int unsigned BIT_CARRIER        = 12;
  localparam int unsigned BIT_SYNC_ACQUIRED  = 11;
  localparam int unsigned BIT_SECONDARY_RX   = 10;
  localparam int unsigned BIT_POWERED_READY  = 9;
  localparam int unsigned BIT_DISCARD_SYNC   = 8;
  localparam int unsigned BIT_CHAR_READY     = 7;
  localparam int unsigned BIT_RX_IRQ_EN      = 6;
  localparam int unsigned BIT_MODEM_IRQ_EN   = 5;
  localparam int unsigned BIT_HUNT_SYNC      = 4;
  localparam int unsigned BIT_SEC_TX         = 3;
  localparam int unsigned BIT_REQ_SEND       = 2;
  localparam int unsigned BIT_TERM_READY     = 1;

  // Number of watched modem inputs
  localparam int unsigned MODEM_LINES = 5;

  // Operating mode from the parameter register
  typedef enum logic [1:0] {
    MODE_INT_SYNC = 2'h0,
    MODE_EXT_SYNC = 2'h1,
    MODE_ISOCH    = 2'h2
  } op_mode_e;

  // Reset values
  localparam logic RESET_BIT          = 1'h0;
  localparam logic [1:0] SYNC_CNT_RESET = 2'h0;
  localparam logic [4:0] MODEM_RESET  = 5'h00;

endpackage

// ==== verilog/sync_hunter.sv ====
/*
  Counts back-to-back sync characters while hunting in internal sync mode
  and reports when the required count is reached.
  Assumes character strobes and the sync match come from the deserialiser.
*/
`timescale 1ns/100ps
`default_nettype none

module sync_hunter (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_resetn,
  // Control
  input  wire logic i_clear,
  input  wire logic i_enable,
  input  wire logic i_need_two,
  // Character stream
  input  wire logic i_char_strobe,
  input  wire logic i_sync_match,
  // Result
  output logic      o_found
);

  typedef enum logic [1:0] {
    HUNT_IDLE = 2'h0,
    HUNT_ONE  = 2'h1,
    HUNT_DONE = 2'h3
  } hunt_state_e;

  hunt_state_e state_reg;
  hunt_state_e state_next;

  always_comb begin
    state_next = state_reg;
    if (i_clear || !i_enable) begin
      state_next = HUNT_IDLE;
    end else if (i_char_strobe) begin
      case (state_reg)
        HUNT_IDLE: begin
          if (i_sync_match) begin
            state_next = i_need_two ? HUNT_ONE : HUNT_DONE;
          end
        end
        HUNT_ONE: begin
          // A non-sync character breaks the contiguous run
          state_next = i_sync_match ? HUNT_DONE : HUNT_IDLE;
        end
        HUNT_DONE: begin
          state_next = HUNT_DONE;
        end
        default: begin
          state_next = HUNT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      state_reg <= HUNT_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_found = (state_reg == HUNT_DONE);

endmodule // sync_hunter

`default_nettype wire

// ==== verilog/rx_status_modem_control.sv ====
/*
  Receiver control and status register with modem status mirroring,
  sync acquisition, character-ready flag and receiver interrupt request.
  Assumes processor bus strobes, modem lines and receiver events are all
  synchronous to i_clk_sys; mode comes from the separate parameter register.
*/
// What this block does
// - Bit 13 reads the modem send-permission input level
// - Bit 12 reads the modem carrier input level
// - Internal sync: sync_acquired sets after one or two contiguous sync characters
// - External sync or isochronous: sync_acquired copies hunt_sync
// - sync_acquired read-only; cleared by init, software clear, hunt_sync falling
// - Bit 10 reads the secondary receive line level
// - Bit 09 reads the modem powered-and-ready input level
// - Discarding on: error-free sync character raises no receiver interrupt
// - discard_sync_chars is read/write; cleared by init and software clear
// - char_ready_flag sets on loaded character once synced, except discarded syncs
// - Receiver interrupt requested while char_ready_flag and receive_irq_enable
// - char_ready_flag read-only; cleared by init, software clear, buffer read strobe
// - receive_irq_enable read/write; cleared by init and software clear
// - modem_irq_enable read/write; cleared by init and software clear
// - Internal sync: hunt_sync enables sync character comparison logic
// - modem_change_flag sets on any modem line change; clears on init, clear, read
// - External sync: hunt_sync enables flags and framing; isochronous: flags only
// - Unused bits read zero; writes to read-only or unused bits ignored
`timescale 1ns/100ps
`default_nettype none

module rx_status_modem_control (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  // Clear sources
  input  wire logic        i_init_pulse,
  input  wire logic        i_software_clear,
  // Register access
  input  wire logic        i_reg_write,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic        i_status_read_strobe,
  output logic      [15:0] o_reg_rdata,
  // Modem status leads
  input  wire logic        i_modem_ring,
  input  wire logic        i_modem_send_permission,
  input  wire logic        i_modem_carrier,
  input  wire logic        i_secondary_receive_line,
  input  wire logic        i_modem_powered_ready,
  // Modem control leads
  output logic             o_secondary_transmit_line,
  output logic             o_request_to_send,
  output logic             o_terminal_ready,
  // Parameter register
  input  wire logic [1:0]  i_op_mode,
  input  wire logic        i_two_sync_chars,
  // Receiver interface
  input  wire logic        i_char_loaded,
  input  wire logic        i_char_is_sync,
  input  wire logic        i_char_error,
  input  wire logic        i_buffer_read_strobe,
  output logic             o_sync_compare_enable,
  output logic             o_framing_enable,
  // Interrupt request
  output logic             o_rx_irq_request
);

  // Mode decode, shared by both receiver enables
  function automatic logic is_mode(input logic [1:0] mode, input rx_status_pkg::op_mode_e m);
    is_mode = (mode == m);
  endfunction

  logic       clear_all;
  logic       int_sync;
  logic       hunter_found;
  logic [4:0] modem_now;

  logic       discard_reg,    discard_next;
  logic       rx_ie_reg,      rx_ie_next;
  logic       modem_ie_reg,   modem_ie_next;
  logic       hunt_reg,       hunt_next;
  logic       sec_tx_reg,     sec_tx_next;
  logic       rts_reg,        rts_next;
  logic       dtr_reg,        dtr_next;
  logic       ready_reg,      ready_next;
  logic       change_reg,     change_next;
  logic       acquired_reg,   acquired_next;
  logic [4:0] modem_prev_reg, modem_prev_next;
  logic       irq_reg,        irq_next;
  logic [15:0] rdata_reg,     rdata_next;
  logic       discard_char;
  logic       synced_now;
  logic       hunt_fall;
  logic [4:0] line_changed;

  assign clear_all = i_init_pulse || i_software_clear;
  assign int_sync  = is_mode(i_op_mode, rx_status_pkg::MODE_INT_SYNC);
  assign modem_now = {i_modem_ring, i_modem_send_permission, i_modem_carrier,
                      i_secondary_receive_line, i_modem_powered_ready};

  // Sync comparison runs only while hunting in internal mode
  assign o_sync_compare_enable = int_sync && hunt_reg;
  assign o_framing_enable = is_mode(i_op_mode, rx_status_pkg::MODE_EXT_SYNC) && hunt_reg;

  // The hunter restarts whenever comparison is switched off
  sync_hunter u_sync_hunter (
    .i_clk_sys     (i_clk_sys),
    .i_resetn      (i_resetn),
    .i_clear       (clear_all),
    .i_enable      (o_sync_compare_enable),
    .i_need_two    (i_two_sync_chars),
    .i_char_strobe (i_char_loaded),
    .i_sync_match  (i_char_is_sync),
    .o_found       (hunter_found)
  );

  // Per-line transition detect
  genvar g;
  generate
    for (g = 0; g < rx_status_pkg::MODEM_LINES; g++) begin : g_line
      assign line_changed[g] = modem_now[g] ^ modem_prev_reg[g];
    end
  endgenerate

  always_comb begin
    discard_next    = discard_reg;
    rx_ie_next      = rx_ie_reg;
    modem_ie_next   = modem_ie_reg;
    hunt_next       = hunt_reg;
    sec_tx_next     = sec_tx_reg;
    rts_next        = rts_reg;
    dtr_next        = dtr_reg;
    modem_prev_next = modem_now;
    hunt_fall       = 1'b0;
    if (i_reg_write) begin
      discard_next  = i_reg_wdata[rx_status_pkg::BIT_DISCARD_SYNC];
      rx_ie_next    = i_reg_wdata[rx_status_pkg::BIT_RX_IRQ_EN];
      modem_ie_next = i_reg_wdata[rx_status_pkg::BIT_MODEM_IRQ_EN];
      hunt_next     = i_reg_wdata[rx_status_pkg::BIT_HUNT_SYNC];
      sec_tx_next   = i_reg_wdata[rx_status_pkg::BIT_SEC_TX];
      rts_next      = i_reg_wdata[rx_status_pkg::BIT_REQ_SEND];
      dtr_next      = i_reg_wdata[rx_status_pkg::BIT_TERM_READY];
    end
    if (clear_all) begin
      discard_next  = rx_status_pkg::RESET_BIT;
      rx_ie_next    = rx_status_pkg::RESET_BIT;
      modem_ie_next = rx_status_pkg::RESET_BIT;
      hunt_next     = rx_status_pkg::RESET_BIT;
      sec_tx_next   = rx_status_pkg::RESET_BIT;
      rts_next      = rx_status_pkg::RESET_BIT;
      dtr_next      = rx_status_pkg::RESET_BIT;
    end
    // A falling hunt_sync, by write or by clear, drops sync_acquired
    hunt_fall = hunt_reg && !hunt_next;
  end

  // Sync acquired group; it sets only while hunting, so a hunter result
  // still standing in the cycle after hunt_sync drops cannot set it again
  always_comb begin
    if (int_sync) begin
      synced_now = hunt_reg && (acquired_reg || hunter_found);
    end else begin
      synced_now = hunt_reg;
    end
    if (clear_all || hunt_fall) begin
      acquired_next = rx_status_pkg::RESET_BIT;
    end else begin
      acquired_next = synced_now;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      acquired_reg <= rx_status_pkg::RESET_BIT;
    end else begin
      acquired_reg <= acquired_next;
    end
  end

  // Character-ready group; error-free sync characters are dropped while discarding
  always_comb begin
    discard_char = discard_reg && i_char_is_sync && !i_char_error;
    ready_next   = ready_reg;
    if (clear_all) begin
      ready_next = rx_status_pkg::RESET_BIT;
    end else if (i_char_loaded && synced_now && hunt_reg && !discard_char) begin
      ready_next = 1'b1;
    end else if (i_buffer_read_strobe) begin
      ready_next = rx_status_pkg::RESET_BIT;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      ready_reg <= rx_status_pkg::RESET_BIT;
    end else begin
      ready_reg <= ready_next;
    end
  end

  // Modem-change group; set wins over a read strobe in the same cycle
  always_comb begin
    change_next = change_reg;
    if (clear_all) begin
      change_next = rx_status_pkg::RESET_BIT;
    end else if (|line_changed) begin
      change_next = 1'b1;
    end else if (i_status_read_strobe) begin
      change_next = rx_status_pkg::RESET_BIT;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      change_reg <= rx_status_pkg::RESET_BIT;
    end else begin
      change_reg <= change_next;
    end
  end

  // Request group; built from next values so it rises with its flag
  always_comb begin
    irq_next = (ready_next && rx_ie_next) || (change_next && modem_ie_next);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      irq_reg <= rx_status_pkg::RESET_BIT;
    end else begin
      irq_reg <= irq_next;
    end
  end

  always_comb begin
    // Unused bit 0 reads zero; every written bit reads back
    rdata_next = 16'h0000;
    rdata_next[rx_status_pkg::BIT_MODEM_CHANGE]  = change_reg;
    rdata_next[rx_status_pkg::BIT_RING]          = i_modem_ring;
    rdata_next[rx_status_pkg::BIT_SEND_PERMIT]   = i_modem_send_permission;
    rdata_next[rx_status_pkg::BIT_CARRIER]       = i_modem_carrier;
    rdata_next[rx_status_pkg::BIT_SYNC_ACQUIRED] = acquired_reg;
    rdata_next[rx_status_pkg::BIT_SECONDARY_RX]  = i_secondary_receive_line;
    rdata_next[rx_status_pkg::BIT_POWERED_READY] = i_modem_powered_ready;
    rdata_next[rx_status_pkg::BIT_DISCARD_SYNC]  = discard_reg;
    rdata_next[rx_status_pkg::BIT_CHAR_READY]    = ready_reg;
    rdata_next[rx_status_pkg::BIT_RX_IRQ_EN]     = rx_ie_reg;
    rdata_next[rx_status_pkg::BIT_MODEM_IRQ_EN]  = modem_ie_reg;
    rdata_next[rx_status_pkg::BIT_HUNT_SYNC]     = hunt_reg;
    rdata_next[rx_status_pkg::BIT_SEC_TX]        = sec_tx_reg;
    rdata_next[rx_status_pkg::BIT_REQ_SEND]      = rts_reg;
    rdata_next[rx_status_pkg::BIT_TERM_READY]    = dtr_reg;
  end

  // Control group
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      discard_reg  <= rx_status_pkg::RESET_BIT;
      rx_ie_reg    <= rx_status_pkg::RESET_BIT;
      modem_ie_reg <= rx_status_pkg::RESET_BIT;
      hunt_reg     <= rx_status_pkg::RESET_BIT;
      sec_tx_reg   <= rx_status_pkg::RESET_BIT;
      rts_reg      <= rx_status_pkg::RESET_BIT;
      dtr_reg      <= rx_status_pkg::RESET_BIT;
    end else begin
      discard_reg  <= discard_next;
      rx_ie_reg    <= rx_ie_next;
      modem_ie_reg <= modem_ie_next;
      hunt_reg     <= hunt_next;
      sec_tx_reg   <= sec_tx_next;
      rts_reg      <= rts_next;
      dtr_reg      <= dtr_next;
    end
  end

  // Line history; a line high when reset is released reports a change
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      modem_prev_reg <= rx_status_pkg::MODEM_RESET;
    end else begin
      modem_prev_reg <= modem_prev_next;
    end
  end

  // Register image
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Control leads follow their stored bits
  assign o_reg_rdata               = rdata_reg;
  assign o_secondary_transmit_line = sec_tx_reg;
  assign o_request_to_send         = rts_reg;
  assign o_terminal_ready          = dtr_reg;
  assign o_rx_irq_request          = irq_reg;

endmodule // rx_status_modem_control

`default_nettype wire

// ==== test/rx_status_assertions.sv ====
/*
  Checker for the receiver control and status register, bound to its top.
  Assumes read data is registered one cycle behind the register state.
*/
`timescale 1ns/100ps
`default_nettype none

module rx_status_assertions (
  input wire logic        i_clk_sys,
  input wire logic        i_resetn,
  input wire logic        i_init_pulse,
  input wire logic        i_software_clear,
  input wire logic        i_modem_send_permission,
  input wire logic        i_modem_carrier,
  input wire logic        i_secondary_receive_line,
  input wire logic        i_modem_powered_ready,
  input wire logic [1:0]  i_op_mode,
  input wire logic [15:0] o_reg_rdata,
  input wire logic        o_sync_compare_enable,
  input wire logic        o_framing_enable,
  input wire logic        o_rx_irq_request
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic [15:0] rd;
  assign rd = o_reg_rdata;

  a_modem_mirror: assert property ($past(i_resetn, 2) |-> {rd[13:12], rd[10:9]} ==
    $past({i_modem_send_permission, i_modem_carrier, i_secondary_receive_line,
           i_modem_powered_ready})) else $error("modem mirror wrong");
  a_clear_all: assert property ((i_init_pulse || i_software_clear) |->
    ##2 (rd & 16'h09F0) == 16'h0000) else $error("clear left bits set");
  a_irq_from_flags: assert property ($past(i_resetn, 2) |-> $past(o_rx_irq_request) ==
    ((rd[7] & rd[6]) | (rd[15] & rd[5]))) else $error("irq request wrong");
  a_copy_hunt: assert property (($past(i_resetn, 3) && i_op_mode != 2'h0 &&
    $past(i_op_mode) != 2'h0 && $past(i_op_mode, 2) != 2'h0) |->
    rd[11] == ($past(rd[4]) && rd[4])) else $error("acquired not following hunt");
  a_unused_zero: assert property (rd[0] == 1'b0) else $error("unused bit set");
  a_hunt_drop: assert property ($fell(rd[4]) |-> ##1 !rd[11])
    else $error("acquired kept after hunt off");
  a_compare_en: assert property ($past(i_resetn, 2) |-> $past(o_sync_compare_enable) ==
    ($past(i_op_mode) == 2'h0 && rd[4])) else $error("compare enable wrong");
  a_framing_en: assert property ($past(i_resetn, 2) |-> $past(o_framing_enable) ==
    ($past(i_op_mode) == 2'h1 && rd[4])) else $error("framing enable wrong");
endmodule // rx_status_assertions

bind rx_status_modem_control rx_status_assertions chk_u (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_init_pulse(i_init_pulse),
  .i_software_clear(i_software_clear), .i_modem_send_permission(i_modem_send_permission),
  .i_modem_carrier(i_modem_carrier), .i_secondary_receive_line(i_secondary_receive_line),
  .i_modem_powered_ready(i_modem_powered_ready), .i_op_mode(i_op_mode),
  .o_reg_rdata(o_reg_rdata), .o_sync_compare_enable(o_sync_compare_enable),
  .o_framing_enable(o_framing_enable), .o_rx_irq_request(o_rx_irq_request)
);

`default_nettype wire

// ==== test/modem_leads_model.sv ====
/*
  Modem status leads model: send permission follows request to send.
  Assumes the bench sets the other lead levels off the rising edge.
*/
`timescale 1ns/100ps
`default_nettype none

module modem_leads_model (
  input  wire logic       i_clk_sys,
  input  wire logic [3:0] i_levels,
  input  wire logic       i_slow,
  input  wire logic       i_request_to_send,
  output logic            o_ring,
  output logic            o_send_permission,
  output logic            o_carrier,
  output logic            o_secondary,
  output logic            o_powered
);
  logic [3:0] rts_dly;
  initial rts_dly = 4'h0;
  // Modem turnaround: one cycle when prompt, four when slow
  always @(negedge i_clk_sys) begin
    rts_dly <= {rts_dly[2:0], i_request_to_send};
  end
  assign o_send_permission = i_slow ? rts_dly[3] : rts_dly[0];
  assign {o_ring, o_carrier, o_secondary, o_powered} = i_levels;
endmodule // modem_leads_model

`default_nettype wire

// ==== test/test_rx_status_modem_control.sv ====
/*
  Self-checking bench for the receiver control and status register.
  Assumes the modem model and the bound checker are compiled alongside.
*/
`timescale 1ns/100ps
`default_nettype none

module test_rx_status_modem_control;
  logic        clk, rstn, init, sclr, wr, srd, two, ld, is_sync, err, brd, slow;
  logic        ring, cts, car, sec, pwr, stx, rts, dtr, cmp_en, frm_en, irq;
  logic [15:0] wdata, rdata;
  logic [1:0]  mode;
  logic [3:0]  levels;
  int          n_mismatch, n_tests, i;

  rx_status_modem_control dut_u (
    .i_clk_sys(clk), .i_resetn(rstn), .i_init_pulse(init), .i_software_clear(sclr),
    .i_reg_write(wr), .i_reg_wdata(wdata), .i_status_read_strobe(srd),
    .o_reg_rdata(rdata), .i_modem_ring(ring), .i_modem_send_permission(cts),
    .i_modem_carrier(car), .i_secondary_receive_line(sec), .i_modem_powered_ready(pwr),
    .o_secondary_transmit_line(stx), .o_request_to_send(rts), .o_terminal_ready(dtr),
    .i_op_mode(mode), .i_two_sync_chars(two), .i_char_loaded(ld),
    .i_char_is_sync(is_sync), .i_char_error(err), .i_buffer_read_strobe(brd),
    .o_sync_compare_enable(cmp_en), .o_framing_enable(frm_en), .o_rx_irq_request(irq)
  );
  modem_leads_model model_u (
    .i_clk_sys(clk), .i_levels(levels), .i_slow(slow), .i_request_to_send(rts),
    .o_ring(ring), .o_send_permission(cts), .o_carrier(car), .o_secondary(sec),
    .o_powered(pwr)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] d);
    wr = 1'b1;
    wdata = d;
    cyc(1);
    wr = 1'b0;
    cyc(3);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(3);
  endtask
  task automatic load(input logic s, input logic e);
    ld = 1'b1;
    is_sync = s;
    err = e;
    cyc(1);
    ld = 1'b0;
    cyc(3);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic t_regs;
    mode = 2'h2;
    slow = 1'b1;
    wr_reg(16'hFFFF);
    chk(rdata & 16'h09FF, 16'h097E);
    chk(16'({stx, rts, dtr}), 16'h0007);
    chk(16'({cmp_en, frm_en}), 16'h0000);
    for (i = 0; i < 10 && rdata[13] !== 1'b1; i++) cyc(1);
    chk(16'(rdata[13]), 16'h0001);
    pulse(init);
    chk(rdata & 16'h09FF, 16'h0000);
    cyc(8);
    pulse(srd);
    $display("t_regs done");
  endtask

  task automatic t_modem;
    logic [15:0] bits [4] = '{16'h4000, 16'h1000, 16'h0400, 16'h0200};
    wr_reg(16'h0020);
    for (int k = 0; k < 4; k++) begin
      levels = 4'h8 >> k;
      cyc(4);
      chk(rdata & 16'h5600, bits[k]);
      chk(rdata & 16'h8000, 16'h8000);
      chk(16'(irq), 16'h0001);
      pulse(srd);
      chk(rdata & 16'h8000, 16'h0000);
    end
    levels = 4'h0;
    cyc(4);
    pulse(srd);
    $display("t_modem done");
  endtask

  task automatic t_char;
    mode = 2'h0;
    two = 1'b1;
    wr_reg(16'h0050);
    chk(16'(cmp_en), 16'h0001);
    load(1'b1, 1'b0);
    load(1'b0, 1'b0);
    load(1'b1, 1'b0);
    chk(rdata & 16'h0800, 16'h0000);
    load(1'b1, 1'b0);
    chk(rdata & 16'h0800, 16'h0800);
    pulse(brd);
    load(1'b0, 1'b0);
    chk(rdata & 16'h0080, 16'h0080);
    chk(16'(irq), 16'h0001);
    pulse(brd);
    chk(rdata & 16'h0080, 16'h0000);
    chk(16'(irq), 16'h0000);
    wr_reg(16'h0150);
    load(1'b1, 1'b0);
    chk(rdata & 16'h0080, 16'h0000);
    load(1'b1, 1'b1);
    chk(rdata & 16'h0080, 16'h0080);
    wr_reg(16'h0140);
    chk(rdata & 16'h0810, 16'h0000);
    mode = 2'h1;
    wr_reg(16'h0010);
    chk(16'({cmp_en, frm_en, rdata[11]}), 16'h0003);
    pulse(sclr);
    chk(rdata & 16'h09F0, 16'h0000);
    $display("t_char done");
  endtask

  initial begin
    cyc(6000);
    n_mismatch++;
    wrap_up;
  end

  initial begin
    n_mismatch = 0;
    n_tests = 0;
    {rstn, init, sclr, wr, srd, two, ld, is_sync, err, brd, slow} = 11'h000;
    wdata = 16'h0000;
    mode = 2'h0;
    levels = 4'h0;
    cyc(20);
    rstn = 1'b1;
    cyc(2);
    t_regs;
    t_modem;
    t_char;
    wrap_up;
  end
endmodule // test_rx_status_modem_control

`default_nettype wire
